// >>> hw/smsp_top.sv
// master/slave serial port core, mode 0 timing
`timescale 1ns/1ps
module smsp_top (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        srst_i,
   // control
   input  wire logic                        enable_i,
   input  wire logic                        master_set_i,
   input  wire logic                        master_clr_i,
   input  wire logic                        bit_order_select_i,
   input  wire logic                        transfer_irq_enable_i,
   input  wire logic [2:0]                  rate_i,
   // user pin directions, one means output
   input  wire logic                        mosi_dir_i,
   input  wire logic                        miso_dir_i,
   input  wire logic                        sck_dir_i,
   input  wire logic                        ss_dir_i,
   input  wire logic                        ss_out_i,
   // data register
   input  wire logic                        data_wr_i,
   input  wire logic [7:0]                  data_wdata_i,
   input  wire logic                        done_clr_i,
   output logic [7:0]                       rx_data_o,
   output logic                             done_o,
   output logic                             irq_o,
   output logic                             master_select_o,
   output logic                             busy_o,
   // pins, enable low drives
   input  wire logic                        sck_i,
   output logic                             sck_o,
   output logic                             sck_oe_n_o,
   input  wire logic                        mosi_i,
   output logic                             mosi_o,
   output logic                             mosi_oe_n_o,
   input  wire logic                        miso_i,
   output logic                             miso_o,
   output logic                             miso_oe_n_o,
   input  wire logic                        ss_n_i,
   output logic                             ss_n_o,
   output logic                             ss_oe_n_o
);
   typedef struct packed {
      smsp_pkg::smsp_state_e state;
      logic                  master;
      logic [7:0]            shreg;
      logic [7:0]            rxbuf;
      logic [2:0]            bitcnt;
      logic                  sck;
      logic                  samp;
      logic                  done;
      logic                  irq;
      logic                  sck_d;
      logic                  ss_d;
      logic                  mosi;
      logic                  miso;
      logic                  sck_oe_n;
      logic                  mosi_oe_n;
      logic                  miso_oe_n;
      logic                  ss_n;
      logic                  ss_oe_n;
      logic [7:0]            rxsh;
      logic [2:0]            rxcnt;
      logic [1:0]            spipe;
      logic                  rxend;
      logic                  txend;
      logic                  busy;
   } smsp_top_s;

   smsp_top_s st_reg;
   smsp_top_s st_next;
   logic      sck_s;
   logic      mosi_s;
   logic      miso_s;
   logic      ss_s;
   logic      tick;
   logic      mrun;
   logic [7:0] tx_out;
   logic       sh_bit;

   ////////////////////////////////////////////////////////////////////
   smsp_sync u_sync_sck (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .rst_val_i (1'b0),
      .d_i       (sck_i),
      .q_o       (sck_s)
   );
   smsp_sync u_sync_mosi (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .rst_val_i (1'b0),
      .d_i       (mosi_i),
      .q_o       (mosi_s)
   );
   smsp_sync u_sync_miso (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .rst_val_i (1'b0),
      .d_i       (miso_i),
      .q_o       (miso_s)
   );
   // select passes inverted so reset value reads as deselected
   logic ss_inv;
   smsp_sync u_sync_ss (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .rst_val_i (1'b0),
      .d_i       (~ss_n_i),
      .q_o       (ss_inv)
   );
   assign ss_s = ~ss_inv;

   assign mrun = (st_reg.state == smsp_pkg::SMSP_MSHIFT);
   smsp_clkdiv u_div (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .run_i  (mrun),
      .rate_i (rate_i),
      .tick_o (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // order select
   always_comb begin
      sh_bit = bit_order_select_i ? st_reg.shreg[0] : st_reg.shreg[7];
      tx_out = st_reg.shreg;
   end

   always_comb begin
      st_next       = st_reg;
      st_next.sck_d = sck_s;
      st_next.ss_d  = ss_s;
      st_next.irq   = 1'b0;
      st_next.spipe = {st_reg.spipe[0], 1'b0};
      if (done_clr_i) begin
         st_next.done = 1'b0;
      end
      if (master_set_i) begin
         st_next.master = 1'b1;
      end else if (master_clr_i) begin
         st_next.master = 1'b0;
      end
      if (!enable_i) begin
         st_next.state = smsp_pkg::SMSP_IDLE;
         st_next.sck   = 1'b0;
         if (data_wr_i) begin
            st_next.shreg = data_wdata_i;
         end
      end else begin
         case (st_reg.state)
            smsp_pkg::SMSP_IDLE: begin
               st_next.sck    = 1'b0;
               st_next.bitcnt = '0;
               st_next.rxcnt  = '0;
               st_next.rxend  = 1'b0;
               st_next.txend  = 1'b0;
               if (data_wr_i) begin
                  st_next.shreg = data_wdata_i;
               end
               if (st_reg.master && !ss_dir_i && !ss_s) begin
                  st_next.master = 1'b0;
                  st_next.done   = 1'b1;
                  st_next.irq    = transfer_irq_enable_i;
               end else if (st_reg.master && data_wr_i) begin
                  st_next.state = smsp_pkg::SMSP_MSHIFT;
               end else if (!st_reg.master && !ss_s) begin
                  st_next.state = smsp_pkg::SMSP_SSHIFT;
               end
            end
            smsp_pkg::SMSP_MSHIFT: begin
               if (!ss_dir_i && !ss_s) begin
                  st_next.master = 1'b0;
                  st_next.done   = 1'b1;
                  st_next.irq    = transfer_irq_enable_i;
                  st_next.state  = smsp_pkg::SMSP_IDLE;
                  st_next.sck    = 1'b0;
               end else begin
                  // miso read two cycles after the rise, behind its synchroniser
                  if (st_reg.spipe[1]) begin
                     st_next.rxsh  = bit_order_select_i ?
                                     {miso_s, st_reg.rxsh[7:1]} :
                                     {st_reg.rxsh[6:0], miso_s};
                     st_next.rxcnt = st_reg.rxcnt + 3'h1;
                     st_next.rxend = (st_reg.rxcnt == smsp_pkg::LAST_BIT);
                  end
                  if (tick && !st_reg.txend) begin
                     st_next.sck = ~st_reg.sck;
                     if (!st_reg.sck) begin
                        st_next.spipe[0] = 1'b1;
                     end else begin
                        // shift on falling edge, count bits
                        st_next.shreg  = bit_order_select_i ?
                                         {1'b0, st_reg.shreg[7:1]} :
                                         {st_reg.shreg[6:0], 1'b0};
                        st_next.bitcnt = st_reg.bitcnt + 3'h1;
                        st_next.txend  = (st_reg.bitcnt == smsp_pkg::LAST_BIT);
                     end
                  end
                  if (st_next.rxend && st_next.txend) begin
                     st_next.state = smsp_pkg::SMSP_IDLE;
                     st_next.rxbuf = st_next.rxsh;
                     st_next.done  = 1'b1;
                     st_next.irq   = transfer_irq_enable_i;
                  end
               end
            end
            smsp_pkg::SMSP_SSHIFT: begin
               if (ss_s) begin
                  st_next.state  = smsp_pkg::SMSP_IDLE;
                  st_next.bitcnt = '0;
               end else if (sck_s && !st_reg.sck_d) begin
                  st_next.samp = mosi_s;
               end else if (!sck_s && st_reg.sck_d) begin
                  st_next.shreg = bit_order_select_i ?
                                  {st_reg.samp, st_reg.shreg[7:1]} :
                                  {st_reg.shreg[6:0], st_reg.samp};
                  st_next.bitcnt = st_reg.bitcnt + 3'h1;
                  if (st_reg.bitcnt == smsp_pkg::LAST_BIT) begin
                     st_next.rxbuf  = bit_order_select_i ?
                                      {st_reg.samp, st_reg.shreg[7:1]} :
                                      {st_reg.shreg[6:0], st_reg.samp};
                     st_next.done   = 1'b1;
                     st_next.irq    = transfer_irq_enable_i;
                     st_next.bitcnt = '0;
                  end
               end else if (data_wr_i && st_reg.bitcnt == 3'h0) begin
                  st_next.shreg = data_wdata_i;
               end
            end
            default: begin
               st_next.state = smsp_pkg::SMSP_IDLE;
            end
         endcase
      end
      if (enable_i && st_next.master) begin
         st_next.mosi_oe_n = ~mosi_dir_i;
         st_next.sck_oe_n  = ~sck_dir_i;
         st_next.miso_oe_n = 1'b1;
         st_next.ss_oe_n   = ~ss_dir_i;
      end else if (enable_i) begin
         st_next.mosi_oe_n = 1'b1;
         st_next.sck_oe_n  = 1'b1;
         st_next.ss_oe_n   = 1'b1;
         st_next.miso_oe_n = ~(miso_dir_i && !ss_s);
      end else begin
         st_next.mosi_oe_n = ~mosi_dir_i;
         st_next.sck_oe_n  = ~sck_dir_i;
         st_next.miso_oe_n = ~miso_dir_i;
         st_next.ss_oe_n   = ~ss_dir_i;
      end
      // select level comes only from user
      st_next.ss_n = ss_out_i;
      // data pins follow the shift register on the same edge
      st_next.mosi = bit_order_select_i ? st_next.shreg[0] : st_next.shreg[7];
      st_next.miso = bit_order_select_i ? st_next.shreg[0] : st_next.shreg[7];
      st_next.busy = (st_next.state != smsp_pkg::SMSP_IDLE);
   end

   ////////////////////////////////////////////////////////////////////
   // reset state
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_reg           <= '0;
         st_reg.state     <= smsp_pkg::SMSP_IDLE;
         st_reg.shreg     <= smsp_pkg::DATA_RST;
         st_reg.rxbuf     <= smsp_pkg::DATA_RST;
         st_reg.ss_d      <= 1'b1;
         st_reg.sck_oe_n  <= 1'b1;
         st_reg.mosi_oe_n <= 1'b1;
         st_reg.miso_oe_n <= 1'b1;
         st_reg.ss_oe_n   <= 1'b1;
         st_reg.ss_n      <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rx_data_o       = st_reg.rxbuf;
   assign done_o          = st_reg.done;
   assign irq_o           = st_reg.irq;
   assign master_select_o = st_reg.master;
   assign busy_o          = st_reg.busy;
   assign sck_o           = st_reg.sck;
   assign sck_oe_n_o      = st_reg.sck_oe_n;
   assign mosi_o          = st_reg.mosi;
   assign mosi_oe_n_o     = st_reg.mosi_oe_n;
   assign miso_o          = st_reg.miso;
   assign miso_oe_n_o     = st_reg.miso_oe_n;
   assign ss_n_o          = st_reg.ss_n;
   assign ss_oe_n_o       = st_reg.ss_oe_n;
   logic unused_ok;
   assign unused_ok = ^{tx_out, st_reg.ss_d, sh_bit};
endmodule

// >>> common/smsp_pkg.sv
// constants and types for the serial master/slave port
// Function
// - master data write starts eight-bit shift
// - master halts clock, sets done flag
// - done flag with enable raises interrupt
// - master never drives select by itself
// - last received byte held in buffer
// - idle slave keeps miso released
// - slave ignores clock while deselected
// - slave sets done after full byte
// - unread receive byte is overwritten
// - enabled port overrides pin directions
// - mosi master to slave, miso back
// - seven master clock rates incl. half
// - both bit orders supported
// - select rise resets slave shift logic
// - select low on master input demotes
// - order bit one means lsb first
package smsp_pkg;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned CNT_W       = 3;
   localparam int unsigned DIV_W       = 7;
   localparam int unsigned RATE_W      = 3;
   localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
   localparam int unsigned CLK_MHZ     = 250;
   localparam int unsigned SCK_MIN_PHASE_CYC = 3;
   // rate select: {double, rate1, rate0}; half period in clock cycles
   localparam logic [DIV_W-1:0] HALF_DIV4   = 7'h02;
   localparam logic [DIV_W-1:0] HALF_DIV16  = 7'h08;
   localparam logic [DIV_W-1:0] HALF_DIV64  = 7'h20;
   localparam logic [DIV_W-1:0] HALF_DIV128 = 7'h40;
   localparam logic [DIV_W-1:0] HALF_DIV2   = 7'h01;
   localparam logic [DIV_W-1:0] HALF_DIV8   = 7'h04;
   localparam logic [DIV_W-1:0] HALF_DIV32  = 7'h10;
   localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

   typedef enum logic [2:0] {
      SMSP_IDLE = 3'b001,
      SMSP_MSHIFT = 3'b010,
      SMSP_SSHIFT = 3'b100
   } smsp_state_e;
endpackage

// >>> hw/smsp_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module smsp_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic rst_val_i,
   // pin
   input  wire logic d_i,
   output logic      q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
   } smsp_sync_s;
   smsp_sync_s st_reg;
   smsp_sync_s st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = d_i;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_reg <= {rst_val_i, rst_val_i};
      end else begin
         st_reg <= st_next;
      end
   end

   assign q_o = st_reg.s2;
endmodule

// >>> hw/smsp_clkdiv.sv
// master clock half-period enable divider
`timescale 1ns/1ps
module smsp_clkdiv (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          srst_i,
   // control
   input  wire logic                          run_i,
   input  wire logic [smsp_pkg::RATE_W-1:0]   rate_i,
   output logic                               tick_o
);
   typedef struct packed {
      logic [smsp_pkg::DIV_W-1:0] cnt;
      logic                       tick;
   } smsp_div_s;
   smsp_div_s st_reg;
   smsp_div_s st_next;
   logic [smsp_pkg::DIV_W-1:0] half;

   always_comb begin
      case (rate_i)
         3'h0:    half = smsp_pkg::HALF_DIV4;
         3'h1:    half = smsp_pkg::HALF_DIV16;
         3'h2:    half = smsp_pkg::HALF_DIV64;
         3'h3:    half = smsp_pkg::HALF_DIV128;
         3'h4:    half = smsp_pkg::HALF_DIV2;
         3'h5:    half = smsp_pkg::HALF_DIV8;
         3'h6:    half = smsp_pkg::HALF_DIV32;
         default: half = smsp_pkg::HALF_DIV64;
      endcase
   end

   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (!run_i) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt >= half - 7'h01) begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_o = st_reg.tick;
endmodule

// >>> dv/smsp_properties.sv
// assertion checker for the serial master/slave port
`timescale 1ns/1ps
module smsp_props_chk (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       srst_i,
   // control
   input wire logic       enable_i,
   input wire logic       transfer_irq_enable_i,
   input wire logic       ss_dir_i,
   input wire logic       ss_out_i,
   // status
   input wire logic [7:0] rx_data_o,
   input wire logic       done_o,
   input wire logic       irq_o,
   input wire logic       master_select_o,
   input wire logic       busy_o,
   // pins
   input wire logic       ss_n_i,
   input wire logic       ss_n_o,
   input wire logic       mosi_oe_n_o,
   input wire logic       sck_oe_n_o,
   input wire logic       miso_oe_n_o,
   input wire logic       ss_oe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // long enough for the select synchroniser to settle
   sequence s_slave_idle;
      (enable_i && !master_select_o && ss_n_i) [*6];
   endsequence
   sequence s_demote_req;
      (enable_i && master_select_o && !ss_dir_i && !ss_n_i) [*2];
   endsequence
   property p_rst_state;
      $fell(srst_i) |-> !done_o && !irq_o && !master_select_o && ss_n_o && rx_data_o == 8'h00;
   endproperty
   property p_idle_miso;
      s_slave_idle |-> miso_oe_n_o;
   endproperty
   property p_idle_busy;
      s_slave_idle |-> !busy_o && $stable(rx_data_o);
   endproperty
   property p_ovr_master;
      (enable_i && master_select_o) [*2] |-> miso_oe_n_o;
   endproperty
   property p_ovr_slave;
      (enable_i && !master_select_o) [*2] |-> mosi_oe_n_o && sck_oe_n_o && ss_oe_n_o;
   endproperty
   property p_done_end;
      master_select_o && $fell(busy_o) |-> ##[0:2] done_o;
   endproperty
   property p_irq_pulse;
      irq_o |-> done_o ##1 !irq_o;
   endproperty
   property p_irq_enable;
      $rose(done_o) && $stable(transfer_irq_enable_i) |-> irq_o == transfer_irq_enable_i;
   endproperty
   property p_rx_done;
      $changed(rx_data_o) |-> done_o;
   endproperty
   property p_ss_abort;
      !master_select_o && busy_o && $rose(ss_n_i) |-> ##[1:4] !busy_o;
   endproperty
   property p_demote;
      s_demote_req |-> ##[0:4] !master_select_o && done_o;
   endproperty
   property p_ss_sw;
      (master_select_o && $stable(ss_out_i)) [*2] |-> ss_n_o == ss_out_i;
   endproperty
   ////////////////////////////////////////////////////////////////////////////////
   a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
   a_idle_miso: assert property (p_idle_miso) else $error("idle miso driven");
   a_idle_busy: assert property (p_idle_busy) else $error("idle slave active");
   a_ovr_master: assert property (p_ovr_master) else $error("master miso driven");
   a_ovr_slave: assert property (p_ovr_slave) else $error("slave pin driven");
   a_done_end: assert property (p_done_end) else $error("no done at end");
   a_irq_pulse: assert property (p_irq_pulse) else $error("bad irq pulse");
   a_irq_enable: assert property (p_irq_enable) else $error("irq vs enable");
   a_rx_done: assert property (p_rx_done) else $error("rx moved without done");
   a_ss_abort: assert property (p_ss_abort) else $error("no abort on select");
   a_demote: assert property (p_demote) else $error("no demotion");
   a_ss_sw: assert property (p_ss_sw) else $error("select not software");
endmodule
bind smsp_top smsp_props_chk u_smsp_props_chk (.clk_i, .srst_i, .enable_i,
   .transfer_irq_enable_i, .ss_dir_i, .ss_out_i, .rx_data_o, .done_o, .irq_o,
   .master_select_o, .busy_o, .ss_n_i, .ss_n_o, .mosi_oe_n_o, .sck_oe_n_o,
   .miso_oe_n_o, .ss_oe_n_o);

// >>> dv/smsp_far_dev.sv
// far side model: slave to a master port, master to a slave port
`timescale 1ns/1ps
module smsp_far_dev (
   // resolved link wires
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic miso_i,
   input  wire logic ss_n_i,
   // lines driven here
   output logic      far_miso_o,
   output logic      far_sck_o,
   output logic      far_mosi_o,
   output logic      far_ss_n_o
);
   localparam int HALF_NS = 16;
   logic       lsb;
   logic [7:0] s_tx;
   logic [7:0] s_rx;
   logic [7:0] m_rx;
   initial begin
      lsb = 1'h0;
      s_tx = 8'h00;
      s_rx = 8'h00;
      m_rx = 8'h00;
      {far_miso_o, far_sck_o, far_mosi_o, far_ss_n_o} = 4'h1;
   end
   // slave: first bit on select, sample on rise, shift on fall
   always @(negedge ss_n_i) far_miso_o = lsb ? s_tx[0] : s_tx[7];
   always @(posedge sck_i) if (!ss_n_i) s_rx = lsb ? {mosi_i, s_rx[7:1]} : {s_rx[6:0], mosi_i};
   always @(negedge sck_i) if (!ss_n_i) begin
      s_tx = lsb ? s_tx >> 1 : s_tx << 1;
      far_miso_o = lsb ? s_tx[0] : s_tx[7];
   end
   // released line shows the inverse
   always @(posedge ss_n_i) far_miso_o = ~far_miso_o;
   // master frame, clock still outside it
   task automatic xfer(input logic [7:0] b, input int bits, input logic sel, input logic o);
      far_ss_n_o = !sel;
      #(2 * HALF_NS);
      for (int i = 0; i < bits; i++) begin
         far_mosi_o = o ? b[i] : b[7-i];
         #HALF_NS far_sck_o = 1'h1;
         m_rx = o ? {miso_i, m_rx[7:1]} : {m_rx[6:0], miso_i};
         #HALF_NS far_sck_o = 1'h0;
      end
      #(2 * HALF_NS) far_ss_n_o = 1'h1;
      far_mosi_o = ~far_mosi_o;
   endtask
endmodule

// >>> dv/smsp_tb_top.sv
// self-checking bench for the serial master/slave port
`timescale 1ns/1ps
module smsp_tb_top;
   logic       clk_i, srst_i, enable_i, master_set_i, master_clr_i, bit_order_select_i;
   logic       transfer_irq_enable_i, mosi_dir_i, miso_dir_i, sck_dir_i, ss_dir_i;
   logic       ss_out_i, data_wr_i, done_clr_i, done_o, irq_o, master_select_o, busy_o;
   logic [2:0] rate_i;
   logic [7:0] data_wdata_i, rx_data_o;
   logic       sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, ss_n_o, ss_oe_n_o;
   logic       far_miso_o, far_sck_o, far_mosi_o, far_ss_n_o;
   wire        sck_i  = sck_oe_n_o ? far_sck_o : sck_o;
   wire        mosi_i = mosi_oe_n_o ? far_mosi_o : mosi_o;
   wire        miso_i = miso_oe_n_o ? far_miso_o : miso_o;
   wire        ss_n_i = ss_oe_n_o ? far_ss_n_o : ss_n_o;
   int         hp[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   int         mismatches, compares;
   smsp_top u_smsp_top (.clk_i, .srst_i, .enable_i, .master_set_i, .master_clr_i,
      .bit_order_select_i, .transfer_irq_enable_i, .rate_i, .mosi_dir_i, .miso_dir_i,
      .sck_dir_i, .ss_dir_i, .ss_out_i, .data_wr_i, .data_wdata_i, .done_clr_i, .rx_data_o,
      .done_o, .irq_o, .master_select_o, .busy_o, .sck_i, .sck_o, .sck_oe_n_o, .mosi_i,
      .mosi_o, .mosi_oe_n_o, .miso_i, .miso_o, .miso_oe_n_o, .ss_n_i, .ss_n_o, .ss_oe_n_o);
   smsp_far_dev u_smsp_far_dev (.sck_i, .mosi_i, .miso_i, .ss_n_i, .far_miso_o, .far_sck_o,
      .far_mosi_o, .far_ss_n_o);
   initial begin
      clk_i = 1'h0;
      forever #2 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wait_done(output int n, output logic ir);
      n = 0;
      ir = 1'h0;
      while (done_o !== 1'h1 && n < 3000) begin
         @(negedge clk_i);
         n++;
         if (irq_o === 1'h1) ir = 1'h1;
      end
   endtask
   task automatic clr_done;
      @(posedge clk_i);
      done_clr_i <= 1'h1;
      ss_out_i <= 1'h1;
      @(posedge clk_i);
      done_clr_i <= 1'h0;
      @(negedge clk_i);
      chk("done clear", 8'h00, {7'h0, done_o});
   endtask
   task automatic t_master(input logic [2:0] r, input logic [7:0] b, input logic [7:0] sb);
      int   n;
      logic ir;
      u_smsp_far_dev.lsb = r[0];
      u_smsp_far_dev.s_tx = sb;
      @(posedge clk_i);
      rate_i <= r;
      bit_order_select_i <= r[0];
      transfer_irq_enable_i <= r[1];
      ss_out_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      data_wr_i <= 1'h1;
      data_wdata_i <= b;
      @(posedge clk_i);
      data_wr_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      // write during shift, must be dropped
      data_wr_i <= 1'h1;
      data_wdata_i <= ~b;
      @(posedge clk_i);
      data_wr_i <= 1'h0;
      wait_done(n, ir);
      chk("master rx", sb, rx_data_o);
      chk("far rx", b, u_smsp_far_dev.s_rx);
      chk("bit time", 8'h01, {7'h0, n + 4 >= 16 * hp[r] && n + 4 <= 16 * hp[r] + 10});
      chk("irq", {7'h0, r[1]}, {7'h0, ir});
      chk("master oe_n", 8'h01, {5'h0, mosi_oe_n_o, sck_oe_n_o, miso_oe_n_o});
      clr_done();
   endtask
   task automatic t_slave(input logic o, input logic [7:0] b, input logic [7:0] sb,
                          input int bits, input logic sel);
      int   n;
      logic ir;
      @(posedge clk_i);
      bit_order_select_i <= o;
      miso_dir_i <= 1'h1;
      data_wr_i <= 1'h1;
      data_wdata_i <= sb;
      @(posedge clk_i);
      data_wr_i <= 1'h0;
      repeat (2) @(negedge clk_i);
      chk("idle pins", 8'h1E,
          {3'h0, miso_oe_n_o, mosi_oe_n_o, sck_oe_n_o, ss_oe_n_o, busy_o});
      u_smsp_far_dev.xfer(b, bits, sel, o);
      if (bits == 8 && sel) begin
         wait_done(n, ir);
         chk("slave rx", b, rx_data_o);
         chk("far rx", sb, u_smsp_far_dev.m_rx);
         clr_done();
      end else begin
         repeat (8) @(negedge clk_i);
         chk("no byte", 8'h00, {6'h0, done_o, busy_o});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {enable_i, master_set_i, master_clr_i, bit_order_select_i, transfer_irq_enable_i} = '0;
      {mosi_dir_i, miso_dir_i, sck_dir_i, ss_dir_i, data_wr_i, done_clr_i} = '0;
      srst_i = 1'h1;
      ss_out_i = 1'h1;
      rate_i = 3'h0;
      data_wdata_i = 8'h00;
      mismatches = 0;
      compares = 0;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'h0;
      @(negedge clk_i);
      chk("reset pins", 8'h0F, {1'h0, done_o, irq_o, master_select_o, sck_oe_n_o,
          mosi_oe_n_o, miso_oe_n_o, ss_oe_n_o});
      chk("reset rx", 8'h00, rx_data_o);
      @(posedge clk_i);
      {enable_i, master_set_i, mosi_dir_i, sck_dir_i, ss_dir_i} <= 5'h1F;
      @(posedge clk_i);
      master_set_i <= 1'h0;
      for (int r = 0; r < 8; r++) t_master(r[2:0], 8'hA5 ^ r[7:0], 8'h3C + r[7:0]);
      @(posedge clk_i);
      ss_dir_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      u_smsp_far_dev.xfer(8'h00, 0, 1'h1, 1'h0);
      @(negedge clk_i);
      chk("demoted", 8'h01, {6'h0, master_select_o, done_o});
      clr_done();
      t_slave(1'h0, 8'hC3, 8'h96, 8, 1'h1);
      t_slave(1'h1, 8'h1E, 8'h7B, 8, 1'h1);
      t_slave(1'h0, 8'hFF, 8'h00, 3, 1'h1);
      t_slave(1'h0, 8'h55, 8'hAA, 8, 1'h0);
      t_slave(1'h1, 8'h81, 8'h42, 8, 1'h1);
      print_verdict();
   end
   initial begin
      #100000;
      mismatches++;
      $display("FAIL watchdog expected end seen timeout");
      print_verdict();
   end
endmodule
